/* bench/dsp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
  // Clock
  input  wire logic i_clock,
  // Programming pins
  output var logic  o_sclk,
  output var logic  o_sdat
);
  // Past the pin filter, well inside the watchdog
  localparam int HOLD = 8;
  initial begin
    o_sclk = 1'b1;
    o_sdat = 1'b1;
  end
  task automatic pins(input logic c, input logic d);
    @(posedge i_clock);
    o_sclk <= c;
    o_sdat <= d;
    repeat (HOLD - 1) @(posedge i_clock);
  endtask
  task automatic unlock();
    pins(1'b1, 1'b1);
    repeat (5) begin
      pins(1'b0, 1'b1);
      pins(1'b1, 1'b1);
    end
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
  endtask
  task automatic put_bit(input logic b);
    pins(1'b1, ~b);
    pins(1'b0, ~b);
    pins(1'b0, b);
    pins(1'b1, b);
  endtask
  task automatic stop();
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    pins(1'b1, 1'b1);
  endtask
  // Caller keeps reserved bits zero
  task automatic frame(input logic [24:0] w, input int nb);
    unlock();
    put_bit(1'b0);
    for (int i = nb - 1; i >= 0; i--) begin
      put_bit(w[i]);
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* bench/tb_dual_synth_serial_program.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_synth_serial_program;
  import dsp_pkg::*;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             pd_n = 1'b1;
  logic             sclk, sdat, prog, ld, err, msb, ostop, ooff;
  logic             tdbl, trim, vref, vmem, mref, vp4, voff, vfm;
  logic [1:0]       sel;
  logic [3:0]       sdiv;
  logic [7:0]       vn, vm, vd, mn, mm, md;
  logic [CTL_W-1:0] ctl;
  int               fails = 0;
  int               num_checks = 0;
  int               loads = 0;
  int               errs = 0;
  int               cycles = 0;

  dsp_serial_program #(.P_WATCHDOG_CYCLES(50)) DUT (
    .i_clock(clk), .i_rst_b(rst_b), .i_select0_serial_clock(sclk),
    .i_select1_serial_data(sdat), .i_powerdown_n(pd_n), .o_reg_select(sel),
    .o_programming(prog), .o_load_pulse(ld), .o_frame_error(err),
    .o_option_control(ctl), .o_standby_divisor(sdiv), .o_memory_from_standby(msb),
    .o_osc_stop(ostop), .o_outputs_off(ooff), .o_timeout_double(tdbl),
    .o_duty_trim_en(trim), .o_video_use_ref(vref), .o_video_use_mem(vmem),
    .o_memory_use_ref(mref), .o_vid_n_eff(vn), .o_vid_m_eff(vm), .o_vid_post_div(vd),
    .o_vid_prescale4(vp4), .o_vid_vco_off(voff), .o_vid_from_mem(vfm),
    .o_mem_n_eff(mn), .o_mem_m_eff(mm), .o_mem_post_div(md)
  );
  dsp_host_model host (.i_clock(clk), .o_sclk(sclk), .o_sdat(sdat));

  initial forever #50 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Pulses are single cycles, so count them as they pass
  always @(posedge clk) begin
    cycles++;
    if (ld === 1'b1) loads++;
    if (err === 1'b1) errs++;
    if (cycles == 40000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [23:0] fw(input logic [3:0] i, input logic [6:0] n,
                                     input logic [2:0] r, input logic [6:0] m,
                                     input logic [2:0] a);
    return {i, n, r, m, a};
  endfunction

  task automatic send(input logic [24:0] w, input int nb, input int el, input int ee);
    int l0, e0;
    l0 = loads;
    e0 = errs;
    host.frame(w, nb);
    repeat (8) @(posedge clk);
    check("load count", loads - l0, el);
    check("error count", errs - e0, ee);
  endtask

  initial begin
    logic [6:0]       n, m;
    logic [2:0]       r;
    logic [3:0]       i;
    logic [CTL_W-1:0] c;
    logic [7:0]       keep;
    int               l0, e0;
    void'($urandom(86));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    check("ctl reset", ctl, CTL_RESET);
    check("trim reset", trim, 1'b0);
    check("standby reset", sdiv, STANDBY_RESET);
    repeat (100) @(posedge clk);
    check("sel idle", sel, 2'b11);
    host.pins(1'b1, 1'b0);
    repeat (100) @(posedge clk);
    check("sel new", sel, 2'b01);
    send({1'b0, fw(4'h0, 7'h10, 3'h1, 7'h08, ADDR_MEMORY)}, 24, 1, 0);
    check("sel held", sel, 2'b01);
    repeat (150) @(posedge clk);
    check("sel after", sel, 2'b11);
    repeat (3) begin
      c = 10'($urandom()) & ~10'h048;
      send({1'b0, 11'h000, c, ADDR_CONTROL}, 24, 1, 0);
      check("ctl", ctl, c);
      check("tdbl", tdbl, c[7]);
      check("trim", trim, !c[5]);
      check("prescale", vp4, c[2]);
    end
    for (int k = 0; k < 8; k++) begin
      n = 7'($urandom());
      m = 7'($urandom());
      r = 3'(k);
      send({1'b0, fw(4'($urandom()), n, r, m, ADDR_MEMORY)}, 24, 1, 0);
      check("mem n", mn, {1'b0, n} + 8'h03);
      check("mem m", mm, {1'b0, m} + 8'h02);
      check("mem div", md, 8'h01 << r);
      check("mem ref", mref, 1'b1);
    end
    i = 4'($urandom());
    send({1'b0, 17'h00000, i, ADDR_STANDBY}, 24, 1, 0);
    check("standby", sdiv, i);
    // Plain index, then the two special codes
    for (int k = 0; k < 3; k++) begin
      i = (k == 0) ? 4'h5 : {3'h7, k[1]};
      n = 7'($urandom());
      m = 7'($urandom());
      r = 3'($urandom());
      send({1'b0, fw(i, n, r, m, ADDR_VIDEO_C)}, 24, 1, 0);
      check("vid n", vn, {1'b0, n} + 8'h03);
      check("vid m", vm, {1'b0, m} + 8'h02);
      check("vid div", vd, 8'h01 << r);
      check("vid off", voff, i[3:1] == 3'h7);
      check("vid mux", vfm, i == 4'hF);
      check("vid fallback", {vmem, vref}, {c[8], ~c[8]});
    end
    keep = vn;
    send({1'b0, fw(4'h5, 7'h00, 3'h0, 7'h00, ADDR_VIDEO_A)}, 24, 1, 0);
    check("inactive vid", vn, keep);
    keep = mn;
    send(25'h0ABCDEB, 23, 0, 1);
    send(25'h1ABCDEB, 25, 0, 1);
    check("rejected", mn, keep);
    l0 = loads;
    e0 = errs;
    host.unlock();
    host.put_bit(1'b0);
    repeat (6) host.put_bit(1'b1);
    check("busy", prog, 1'b1);
    repeat (250) @(posedge clk);
    check("relock", prog, 1'b0);
    host.stop();
    repeat (8) @(posedge clk);
    check("wd load", loads - l0, 0);
    check("wd err", errs - e0, 0);
    for (int k = 0; k < 2; k++) begin
      send({1'b0, 11'h000, k[0], 9'h020, ADDR_CONTROL}, 24, 1, 0);
      pd_n <= 1'b0;
      repeat (8) @(posedge clk);
      check("standby mem", msb, !k[0]);
      check("osc stop", {ostop, ooff}, {k[0], k[0]});
      send({1'b0, fw(4'h0, 7'h7F, 3'h0, 7'h7F, ADDR_MEMORY)}, 24, 0, 0);
      check("pd refused", mn, keep);
      pd_n <= 1'b1;
    end
    close_out();
  end
endmodule
`default_nettype wire

/* logic/dsp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dsp_level_if;
  logic level;
  modport src (output level);
  modport dst (input level);
endinterface

interface dsp_timer_if;
  logic restart;
  logic dbl;
  logic expired;
  modport tmr (input restart, input dbl, output expired);
  modport ctl (output restart, output dbl, input expired);
endinterface
`default_nettype wire

/* logic/dsp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dsp_pin_sync #(
  parameter logic P_RESET = 1'b0
) (
  // Clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst_b,
  // Pin and filtered level
  input  wire logic  i_pin,
  dsp_level_if.src   o_lvl
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg <= P_RESET;
      s2_reg <= P_RESET;
      s3_reg <= P_RESET;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change only when the last two stages agree
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lvl.level <= P_RESET;
    end else if (s2_reg == s3_reg) begin
      o_lvl.level <= s2_reg;
    end
  end
endmodule
`default_nettype wire

/* logic/dsp_pkg.sv */
package dsp_pkg;
  // Clock and time-out
  localparam int CLOCK_HZ        = 10_000_000;
  localparam int WATCHDOG_MS     = 2;
  localparam int WATCHDOG_CYCLES = WATCHDOG_MS * (CLOCK_HZ / 1000);

  // Unlock and frame
  localparam int UNLOCK_ONES  = 5;
  localparam int WORD_BITS    = 24;
  localparam int DATA_BITS    = 21;
  localparam int ADDR_BITS    = 3;
  localparam int BITCNT_W     = 5;

  // Register addresses
  localparam logic [2:0] ADDR_VIDEO_A = 3'h0;
  localparam logic [2:0] ADDR_VIDEO_B = 3'h1;
  localparam logic [2:0] ADDR_VIDEO_C = 3'h2;
  localparam logic [2:0] ADDR_MEMORY  = 3'h3;
  localparam logic [2:0] ADDR_STANDBY = 3'h4;
  localparam logic [2:0] ADDR_CONTROL = 3'h6;

  // Frequency word fields, positions inside the 21-bit data
  localparam int IDX_LSB = 17;
  localparam int N_LSB   = 10;
  localparam int R_LSB   = 7;
  localparam int M_LSB   = 0;
  localparam int IDX_W   = 4;
  localparam int NM_W    = 7;
  localparam int R_W     = 3;
  localparam logic [7:0] N_OFFSET = 8'h03;
  localparam logic [7:0] M_OFFSET = 8'h02;
  localparam logic [3:0] IDX_VCO_OFF  = 4'hE;
  localparam logic [3:0] IDX_MEM_MUX  = 4'hF;

  // Option control layout
  localparam int CTL_W                 = 10;
  localparam int CTL_POWERDOWN_KIND    = 9;
  localparam int CTL_TRANSITION_SOURCE = 8;
  localparam int CTL_TIMEOUT_DOUBLE    = 7;
  localparam int CTL_DUTY_TRIM_OFF     = 5;
  localparam int CTL_PRESCALE_V0       = 0;
  localparam logic [CTL_W-1:0] CTL_RESET = 10'h020;
  localparam logic [CTL_W-1:0] CTL_WMASK = 10'h3B7;

  // Register reset values
  localparam logic [DATA_BITS-1:0] FREQ_RESET    = 21'h000000;
  localparam logic [3:0]           STANDBY_RESET = 4'h8;

  typedef enum logic [0:0] {
    ST_LOCKED,
    ST_SHIFT
  } dsp_state_t;
endpackage

/* logic/dsp_serial_program.sv */
// Functional notes
// [RQ1] Control bit 9 clear: memory output from standby divisor; set: oscillator and outputs off.
// [RQ2] Control bit 8 picks reference or memory clock for video during changes.
// [RQ3] Time-out counts the normal interval; control bit 7 doubles it.
// [RQ4] Programmer writes zero to control bits 6 and 3.
// [RQ5] Control bit 5, reset one; clear enables the duty-cycle trim.
// [RQ6] Each video register has its own prescale select: 2 clear, 4 set.
// [RQ7] No serial programming while powered down.
// [RQ8] Select pin 0 is the serial clock, select pin 1 the serial data.
// [RQ9] Five or more rising edges with data high, then one with data low, unlock.
// [RQ10] Any pin transition restarts the watchdog; expiry relocks and drops the word.
// [RQ11] Select changes reach the decoder only after the watchdog expires.
// [RQ12] Bit taken on rising edge; its complement stood at the previous falling edge.
// [RQ13] Frame: start bit, 21 data bits, 3 address bits, stop bit.
// [RQ14] Exactly 24 bits before the stop, otherwise error and word rejected.
// [RQ15] Stop is data high on fall and rise; loads addressed register, then relocks.
// [RQ16] After a load, selection resumes only after another time-out.
// [RQ17] Bits beyond a full register without stop discard the word with error.
// [RQ18] Word fields high to low: 4-bit index, 7-bit N, 3-bit divisor, 7-bit M.
// [RQ19] Effective N is N plus three, effective M is M plus two.
// [RQ20] Output divisor is two to the power of the 3-bit field.
// [RQ21] Video index 1110 turns its oscillator off, 1111 muxes memory oscillator in.
// [RQ22] Programmer keeps the oscillator between 50 and 120 MHz.
// [RQ23] Addresses: 0..2 video, 3 memory, 4 standby divisor, 6 control.
// [RQ24] Reprogrammed active output runs from the fallback clock for a settle time-out.
// [RQ25] An error returns the unlock detector to its locked idle state.
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_program #(
  parameter int P_WATCHDOG_CYCLES = dsp_pkg::WATCHDOG_CYCLES
) (
  // Clock and reset
  input  wire logic                         i_clock,
  input  wire logic                         i_rst_b,
  // Device pins
  input  wire logic                         i_select0_serial_clock,
  input  wire logic                         i_select1_serial_data,
  input  wire logic                         i_powerdown_n,
  // Selection and frame status
  output logic [1:0]                        o_reg_select,
  output logic                              o_programming,
  output logic                              o_load_pulse,
  output logic                              o_frame_error,
  // Option control and power
  output logic [dsp_pkg::CTL_W-1:0]         o_option_control,
  output logic [3:0]                        o_standby_divisor,
  output logic                              o_memory_from_standby,
  output logic                              o_osc_stop,
  output logic                              o_outputs_off,
  output logic                              o_timeout_double,
  output logic                              o_duty_trim_en,
  // Fallback during frequency changes
  output logic                              o_video_use_ref,
  output logic                              o_video_use_mem,
  output logic                              o_memory_use_ref,
  // Active video synthesis
  output logic [7:0]                        o_vid_n_eff,
  output logic [7:0]                        o_vid_m_eff,
  output logic [7:0]                        o_vid_post_div,
  output logic                              o_vid_prescale4,
  output logic                              o_vid_vco_off,
  output logic                              o_vid_from_mem,
  // Memory synthesis
  output logic [7:0]                        o_mem_n_eff,
  output logic [7:0]                        o_mem_m_eff,
  output logic [7:0]                        o_mem_post_div
);
  import dsp_pkg::*;

  dsp_level_if sclk_if ();
  dsp_level_if sdat_if ();
  dsp_level_if pdn_if ();
  dsp_timer_if wd_if ();
  dsp_timer_if setv_if ();
  dsp_timer_if setm_if ();

  dsp_pin_sync #(.P_RESET(1'b0)) u_sync_clk (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .i_pin (i_select0_serial_clock), .o_lvl (sclk_if)
  ); // see [RQ8]
  dsp_pin_sync #(.P_RESET(1'b0)) u_sync_dat (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .i_pin (i_select1_serial_data), .o_lvl (sdat_if)
  ); // see [RQ8]
  dsp_pin_sync #(.P_RESET(1'b1)) u_sync_pd (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .i_pin (i_powerdown_n), .o_lvl (pdn_if)
  );
  dsp_timeout #(.P_CYCLES(P_WATCHDOG_CYCLES)) u_watchdog (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .t (wd_if)
  );
  dsp_timeout #(.P_CYCLES(P_WATCHDOG_CYCLES)) u_settle_vid (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .t (setv_if)
  );
  dsp_timeout #(.P_CYCLES(P_WATCHDOG_CYCLES)) u_settle_mem (
    .i_clock (i_clock), .i_rst_b (i_rst_b), .t (setm_if)
  );

  dsp_state_t           state_reg;
  logic                 clk_q_reg;
  logic                 dat_q_reg;
  logic                 fall_val_reg;
  logic [2:0]           ones_reg;
  logic                 start_seen_reg;
  logic [BITCNT_W-1:0]  bcnt_reg;
  logic [WORD_BITS-1:0] shift_reg;
  logic [DATA_BITS-1:0] vid_reg [3];
  logic [DATA_BITS-1:0] mem_reg;
  logic [3:0]           standby_reg;
  logic [CTL_W-1:0]     ctl_reg;
  logic [1:0]           sel_reg;

  logic                 sclk;
  logic                 sdat;
  logic                 pd_active;
  logic                 rise;
  logic                 fall;
  logic                 any_edge;
  logic                 is_bit;
  logic                 is_stop;
  logic                 good_stop;
  logic                 do_load;
  logic                 do_error;
  logic [2:0]           load_addr;
  logic [DATA_BITS-1:0] load_data;
  logic [1:0]           sel_next;
  logic                 sel_change;
  logic [1:0]           active_v;
  logic [DATA_BITS-1:0] act_word;

  assign sclk      = sclk_if.level;
  assign sdat      = sdat_if.level;
  assign pd_active = !pdn_if.level;
  assign rise      = sclk && !clk_q_reg;
  assign fall      = !sclk && clk_q_reg;
  assign any_edge  = (sclk != clk_q_reg) || (sdat != dat_q_reg);
  assign is_bit    = rise && (fall_val_reg != sdat); // see [RQ12]
  assign is_stop   = rise && fall_val_reg && sdat; // see [RQ15]
  assign load_addr = shift_reg[ADDR_BITS-1:0];
  assign load_data = shift_reg[WORD_BITS-1:ADDR_BITS];
  assign good_stop = is_stop && start_seen_reg && (bcnt_reg == BITCNT_W'(WORD_BITS));
  assign do_load   = (state_reg == ST_SHIFT) && !pd_active && !wd_if.expired && good_stop;
  // Both-low rise, short stop or overflow bit all reject the word
  assign do_error  = (state_reg == ST_SHIFT) && !pd_active && !wd_if.expired && rise &&
                     ((is_stop && !good_stop) || (!fall_val_reg && !sdat) ||
                      (is_bit && start_seen_reg && (bcnt_reg == BITCNT_W'(WORD_BITS))));
  // see [RQ14] see [RQ17]

  // Watchdog restarted by any transition on the two select pins
  assign wd_if.restart = any_edge; // see [RQ10]
  assign wd_if.dbl     = ctl_reg[CTL_TIMEOUT_DOUBLE]; // see [RQ3]

  // Selection follows the pins only while idle and timed out
  assign sel_next   = {sdat, sclk};
  // Edge in the expiry cycle restarts the count, so it waits a full time-out too
  assign sel_change = (state_reg == ST_LOCKED) && wd_if.expired && !any_edge &&
                      (sel_next != sel_reg);
  assign active_v   = sel_reg[1] ? 2'h2 : sel_reg;

  assign setv_if.restart = sel_change ||
                           (do_load && (load_addr == {1'b0, active_v})); // see [RQ24]
  assign setv_if.dbl     = ctl_reg[CTL_TIMEOUT_DOUBLE];
  assign setm_if.restart = do_load && (load_addr == ADDR_MEMORY); // see [RQ24]
  assign setm_if.dbl     = ctl_reg[CTL_TIMEOUT_DOUBLE];
  assign act_word        = vid_reg[active_v];

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_q_reg    <= 1'b0;
      dat_q_reg    <= 1'b0;
      fall_val_reg <= 1'b0;
    end else begin
      clk_q_reg <= sclk;
      dat_q_reg <= sdat;
      if (fall) begin
        fall_val_reg <= sdat; // see [RQ12]
      end
    end
  end

  // Unlock detector and frame shifter
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg      <= ST_LOCKED;
      ones_reg       <= 3'h0;
      start_seen_reg <= 1'b0;
      bcnt_reg       <= '0;
      shift_reg      <= '0;
    end else if (pd_active) begin
      state_reg <= ST_LOCKED; // see [RQ7]
      ones_reg  <= 3'h0;
    end else begin
      case (state_reg)
        ST_LOCKED: begin
          if (wd_if.expired) begin
            ones_reg <= 3'h0;
          end else if (rise && sdat) begin
            if (ones_reg != 3'(UNLOCK_ONES)) begin
              ones_reg <= ones_reg + 3'h1;
            end
          end else if (rise) begin
            ones_reg <= 3'h0;
            if (ones_reg == 3'(UNLOCK_ONES)) begin
              state_reg      <= ST_SHIFT; // see [RQ9]
              start_seen_reg <= 1'b0;
              bcnt_reg       <= '0;
            end
          end
        end
        ST_SHIFT: begin
          if (wd_if.expired || do_error || do_load) begin
            state_reg <= ST_LOCKED; // see [RQ10] see [RQ15] see [RQ25]
            ones_reg  <= 3'h0;
          end else if (is_bit) begin
            if (!start_seen_reg) begin
              start_seen_reg <= 1'b1; // see [RQ13]
            end else begin
              shift_reg <= {shift_reg[WORD_BITS-2:0], sdat};
              bcnt_reg  <= bcnt_reg + 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_LOCKED;
        end
      endcase
    end
  end

  // Register file load
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vid_reg[0]  <= FREQ_RESET;
      vid_reg[1]  <= FREQ_RESET;
      vid_reg[2]  <= FREQ_RESET;
      mem_reg     <= FREQ_RESET;
      standby_reg <= STANDBY_RESET;
      ctl_reg     <= CTL_RESET;
    end else if (do_load) begin
      if (load_addr == ADDR_VIDEO_A) begin // see [RQ23]
        vid_reg[0] <= load_data;
      end else if (load_addr == ADDR_VIDEO_B) begin
        vid_reg[1] <= load_data;
      end else if (load_addr == ADDR_VIDEO_C) begin
        vid_reg[2] <= load_data;
      end else if (load_addr == ADDR_MEMORY) begin
        mem_reg <= load_data;
      end else if (load_addr == ADDR_STANDBY) begin
        standby_reg <= load_data[3:0];
      end else if (load_addr == ADDR_CONTROL) begin
        // Reserved bits forced low in case the programmer ignores them
        ctl_reg <= load_data[CTL_W-1:0] & CTL_WMASK; // see [RQ4]
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_reg <= 2'h0;
    end else if (sel_change) begin
      sel_reg <= sel_next; // see [RQ11] see [RQ16]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_load_pulse  <= 1'b0;
      o_frame_error <= 1'b0;
      o_programming <= 1'b0;
    end else begin
      o_load_pulse  <= do_load;
      o_frame_error <= do_error;
      o_programming <= (state_reg == ST_SHIFT);
    end
  end

  // Decoded outputs, one cycle behind the register file
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_select          <= 2'h0;
      o_option_control      <= CTL_RESET;
      o_standby_divisor     <= STANDBY_RESET;
      o_memory_from_standby <= 1'b0;
      o_osc_stop            <= 1'b0;
      o_outputs_off         <= 1'b0;
      o_timeout_double      <= 1'b0;
      o_duty_trim_en        <= 1'b0;
      o_video_use_ref       <= 1'b0;
      o_video_use_mem       <= 1'b0;
      o_memory_use_ref      <= 1'b0;
      o_vid_n_eff           <= 8'h00;
      o_vid_m_eff           <= 8'h00;
      o_vid_post_div        <= 8'h00;
      o_vid_prescale4       <= 1'b0;
      o_vid_vco_off         <= 1'b0;
      o_vid_from_mem        <= 1'b0;
      o_mem_n_eff           <= 8'h00;
      o_mem_m_eff           <= 8'h00;
      o_mem_post_div        <= 8'h00;
    end else begin
      o_reg_select          <= sel_reg;
      o_option_control      <= ctl_reg;
      o_standby_divisor     <= standby_reg;
      o_memory_from_standby <= pd_active && !ctl_reg[CTL_POWERDOWN_KIND]; // see [RQ1]
      o_osc_stop            <= pd_active && ctl_reg[CTL_POWERDOWN_KIND]; // see [RQ1]
      o_outputs_off         <= pd_active && ctl_reg[CTL_POWERDOWN_KIND]; // see [RQ1]
      o_timeout_double      <= ctl_reg[CTL_TIMEOUT_DOUBLE]; // see [RQ3]
      o_duty_trim_en        <= !ctl_reg[CTL_DUTY_TRIM_OFF]; // see [RQ5]
      o_video_use_ref       <= !setv_if.expired && !ctl_reg[CTL_TRANSITION_SOURCE]; // see [RQ2]
      o_video_use_mem       <= !setv_if.expired && ctl_reg[CTL_TRANSITION_SOURCE]; // see [RQ2]
      o_memory_use_ref      <= !setm_if.expired; // see [RQ24]
      o_vid_n_eff    <= {1'b0, act_word[N_LSB +: NM_W]} + N_OFFSET; // see [RQ18] see [RQ19]
      o_vid_m_eff    <= {1'b0, act_word[M_LSB +: NM_W]} + M_OFFSET; // see [RQ19]
      o_vid_post_div <= 8'h01 << act_word[R_LSB +: R_W]; // see [RQ20]
      o_vid_prescale4 <= ctl_reg[CTL_PRESCALE_V0 + 32'(active_v)]; // see [RQ6]
      o_vid_vco_off  <= (act_word[IDX_LSB +: IDX_W] == IDX_VCO_OFF) ||
                        (act_word[IDX_LSB +: IDX_W] == IDX_MEM_MUX); // see [RQ21]
      o_vid_from_mem <= (act_word[IDX_LSB +: IDX_W] == IDX_MEM_MUX); // see [RQ21]
      o_mem_n_eff    <= {1'b0, mem_reg[N_LSB +: NM_W]} + N_OFFSET; // see [RQ19]
      o_mem_m_eff    <= {1'b0, mem_reg[M_LSB +: NM_W]} + M_OFFSET; // see [RQ19]
      o_mem_post_div <= 8'h01 << mem_reg[R_LSB +: R_W]; // see [RQ20]
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  unlock_entry_a: assert property ((state_reg == ST_LOCKED) && !pd_active && !wd_if.expired &&
    rise && !sdat && (ones_reg == 3'(UNLOCK_ONES)) |=> state_reg == ST_SHIFT) // see [RQ9]
    else $error("unlock sequence not accepted");
  load_full_a: assert property (is_stop && start_seen_reg && // see [RQ14]
    (state_reg == ST_SHIFT) && !pd_active && !wd_if.expired &&
    bcnt_reg != BITCNT_W'(WORD_BITS) |=> o_frame_error && !o_load_pulse)
    else $error("short frame loaded");
  load_relock_a: assert property (do_load |=> o_load_pulse && state_reg == ST_LOCKED) // see [RQ15]
    else $error("load did not relock");
  error_relock_a: assert property (do_error |=> o_frame_error && state_reg == ST_LOCKED) // see [RQ25]
    else $error("error did not relock");
  overflow_err_a: assert property ((state_reg == ST_SHIFT) && !pd_active && !wd_if.expired &&
    is_bit && start_seen_reg && bcnt_reg == BITCNT_W'(WORD_BITS) |=> o_frame_error) // see [RQ17]
    else $error("overflow bit not flagged");
  pd_refuse_a: assert property (pd_active |=> state_reg == ST_LOCKED && !o_load_pulse) // see [RQ7]
    else $error("programming while powered down");
  wd_relock_a: assert property ((state_reg == ST_SHIFT) && wd_if.expired && !pd_active
    |=> state_reg == ST_LOCKED && !o_load_pulse) // see [RQ10]
    else $error("watchdog expiry kept frame");
  sel_hold_a: assert property (!wd_if.expired || any_edge || // see [RQ11]
    state_reg == ST_SHIFT |=> $stable(sel_reg))
    else $error("selection moved before time-out");
  ctl_mask_a: assert property (do_load && load_addr == ADDR_CONTROL
    |=> ##1 o_option_control == ($past(load_data[CTL_W-1:0], 2) & CTL_WMASK)) // see [RQ4]
    else $error("control write wrong");
  mem_neff_a: assert property (do_load && load_addr == ADDR_MEMORY
    |=> ##1 o_mem_n_eff == {1'b0, $past(load_data[N_LSB +: NM_W], 2)} + N_OFFSET) // see [RQ19]
    else $error("memory N not offset by three");
  settle_mem_a: assert property (do_load && load_addr == ADDR_MEMORY |=> ##1 o_memory_use_ref) // see [RQ24]
    else $error("memory fallback missing");

  load_c: cover property (o_load_pulse);
  error_c: cover property (o_frame_error);
  unlock_c: cover property ((state_reg == ST_LOCKED) ##1 (state_reg == ST_SHIFT));
  timeout_c: cover property ((state_reg == ST_SHIFT) && wd_if.expired);
endmodule
`default_nettype wire

/* logic/dsp_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
module dsp_timeout #(
  parameter int P_CYCLES = 20000
) (
  // Clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst_b,
  // Timer control
  dsp_timer_if.tmr   t
);
  localparam int W = $clog2(2 * P_CYCLES + 1);
  localparam logic [W-1:0] LIM1 = W'(P_CYCLES);
  localparam logic [W-1:0] LIM2 = W'(2 * P_CYCLES);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] limit;

  assign limit     = t.dbl ? LIM2 : LIM1;
  assign t.expired = (cnt_reg >= limit);

  // Starts expired so that selection works straight after reset
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '1;
    end else if (t.restart) begin
      cnt_reg <= '0;
    end else if (cnt_reg < limit) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire
